// *** rtl/in_service_stack.sv ***
// One path's in-service register: set on vector read, clear lowest bit.
`timescale 1ns/1ps
module in_service_stack (
	input wire logic clock, // System clock.
	input wire logic srst, // Synchronous reset.
	input wire logic set_en, // Vector read with nesting on.
	input wire logic [nest_pkg::LVL_W-1:0] set_level, // Level to mark.
	input wire logic clear_en, // Write to the in-service register.
	output logic [nest_pkg::NUM_LVL-1:0] state_reg // In-service bits.
);
	import nest_pkg::*;
	logic [NUM_LVL-1:0] state_next;
	wire [NUM_LVL-1:0] lowest_bit = state_reg & (~state_reg + NUM_LVL'(1));
	wire [NUM_LVL-1:0] set_bit = NUM_LVL'(1) << set_level;
	wire [NUM_LVL-1:0] after_clear = clear_en ? state_reg & ~lowest_bit
		: state_reg;
	// A set in the same cycle as a clear is ORed in after the clear, so both take effect.
	assign state_next = set_en ? after_clear | set_bit : after_clear;
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	a_clear_one: assert property (@(posedge clock) disable iff (srst)
		clear_en && !set_en && state_reg != 0 |=>
		$countones($past(state_reg)) - $countones(state_reg) == 1)
		else $error("in-service clear did not drop exactly one bit");
	a_clear_low: assert property (@(posedge clock) disable iff (srst)
		clear_en && !set_en |=> (state_reg & $past(lowest_bit)) == 0)
		else $error("in-service clear left the lowest bit");
	a_set_mark: assert property (@(posedge clock) disable iff (srst)
		set_en |=> state_reg[$past(set_level)])
		else $error("in-service bit not set on vector read");
endmodule : in_service_stack

// *** rtl/nest_pkg.sv ***
// Package with register map, field layout and widths of the nesting block.
package nest_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int NUM_SRC = 28;
	localparam int SRC_W = 5;
	localparam int LVL_W = 3;
	localparam int NUM_LVL = 8;
	localparam int BASE_W = 16;
	localparam logic [ADDR_W-1:0] VECTOR_TABLE_BASE_ADDR = 32'hFFFF0014;
	localparam logic [ADDR_W-1:0] NORMAL_VECTOR_ADDR = 32'hFFFF001C;
	localparam logic [ADDR_W-1:0] PRIORITY_LEVELS_C_ADDR = 32'hFFFF0028;
	localparam logic [ADDR_W-1:0] PRIORITY_LEVELS_D_ADDR = 32'hFFFF002C;
	localparam logic [ADDR_W-1:0] NESTING_CONTROL_ADDR = 32'hFFFF0030;
	localparam logic [ADDR_W-1:0] NORMAL_IN_SERVICE_ADDR = 32'hFFFF003C;
	localparam logic [ADDR_W-1:0] FAST_VECTOR_ADDR = 32'hFFFF011C;
	localparam logic [ADDR_W-1:0] FAST_IN_SERVICE_ADDR = 32'hFFFF013C;
	localparam logic [DATA_W-1:0] PRIO_C_MASK = 32'h77777777;
	localparam logic [DATA_W-1:0] PRIO_D_MASK = 32'h00007777;
	localparam logic [DATA_W-1:0] CTRL_MASK = 32'h00000003;
	localparam logic [DATA_W-1:0] RESET_VALUE = 32'h00000000;
	localparam int NORMAL_NEST_BIT = 0;
	localparam int FAST_NEST_BIT = 1;
	localparam int VEC_BASE_LSB = 7;
	localparam int VEC_SRC_LSB = 2;
	localparam int FIELD_STRIDE = 4;
	// Source numbers of the sources whose levels live in registers c and d.
	localparam int SRC_TWA_SLAVE = 16;
	localparam int SRC_TWB_MASTER = 17;
	localparam int SRC_TWB_SLAVE = 18;
	localparam int SRC_EXT0 = 19;
	localparam int SRC_PWM = 23;
	localparam int SRC_EXT4 = 24;
	localparam int SRC_LA_A = 26;
endpackage : nest_pkg

// *** rtl/nested_priority_interrupt_ctrl.sv ***
// Nesting, priority and vector registers of the interrupt controller.
`timescale 1ns/1ps
module nested_priority_interrupt_ctrl #(
	parameter int NSRC = nest_pkg::NUM_SRC // Number of interrupt sources.
) (
	input wire logic clock, // System clock, 100 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [nest_pkg::ADDR_W-1:0] addr, // Register address.
	input wire logic [nest_pkg::DATA_W-1:0] wdata, // Write data.
	input wire logic wr_stb, // Write strobe.
	input wire logic rd_stb, // Read strobe.
	output logic [nest_pkg::DATA_W-1:0] rdata, // Read data, next cycle.
	input wire logic [nest_pkg::NUM_SRC-1:0] normal_pending, // Normal reqs.
	input wire logic [nest_pkg::NUM_SRC-1:0] fast_pending, // Fast reqs.
	input wire logic [nest_pkg::NUM_SRC*nest_pkg::LVL_W-1:0] low_levels,
	// Levels of sources 0 to 15, held by the earlier priority registers.
	output logic normal_irq, // Normal interrupt to the core.
	output logic fast_irq // Fast interrupt to the core.
);
	import nest_pkg::*;

	generate
		if (NSRC != NUM_SRC) begin : g_bad_nsrc
			$error("NSRC must equal the number of decoded sources");
		end
	endgenerate

	logic [DATA_W-1:0] prio_c_reg;
	logic [DATA_W-1:0] prio_d_reg;
	logic [DATA_W-1:0] ctrl_reg;
	logic [BASE_W-1:0] base_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [NUM_LVL-1:0] normal_isr;
	logic [NUM_LVL-1:0] fast_isr;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] r);
		hit = (a == r);
	endfunction : hit

	wire wr_prio_c = wr_stb && hit(addr, PRIORITY_LEVELS_C_ADDR);
	wire wr_prio_d = wr_stb && hit(addr, PRIORITY_LEVELS_D_ADDR);
	wire wr_ctrl = wr_stb && hit(addr, NESTING_CONTROL_ADDR);
	wire wr_base = wr_stb && hit(addr, VECTOR_TABLE_BASE_ADDR);
	wire wr_nisr = wr_stb && hit(addr, NORMAL_IN_SERVICE_ADDR);
	wire wr_fisr = wr_stb && hit(addr, FAST_IN_SERVICE_ADDR);
	wire rd_nvec = rd_stb && hit(addr, NORMAL_VECTOR_ADDR);
	wire rd_fvec = rd_stb && hit(addr, FAST_VECTOR_ADDR);

	wire normal_nest = ctrl_reg[NORMAL_NEST_BIT];
	wire fast_nest = ctrl_reg[FAST_NEST_BIT];

	// Level table: low sources from outside, the rest from c and d.
	logic [NUM_SRC*LVL_W-1:0] levels;
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_lvl
			if (g >= SRC_EXT4) begin : g_d
				assign levels[g*LVL_W +: LVL_W] =
					prio_d_reg[(g-SRC_EXT4)*FIELD_STRIDE +: LVL_W];
			end else if (g >= SRC_TWA_SLAVE) begin : g_c
				assign levels[g*LVL_W +: LVL_W] =
					prio_c_reg[(g-SRC_TWA_SLAVE)*FIELD_STRIDE +: LVL_W];
			end else begin : g_low
				assign levels[g*LVL_W +: LVL_W] = low_levels[g*LVL_W +: LVL_W];
			end
		end
	endgenerate

	logic n_found;
	logic f_found;
	logic [SRC_W-1:0] n_src;
	logic [SRC_W-1:0] f_src;
	logic [LVL_W-1:0] n_lvl;
	logic [LVL_W-1:0] f_lvl;

	priority_pick u_normal_pick (
		.pending(normal_pending),
		.levels(levels),
		.prio_on(normal_nest),
		.in_service(normal_isr),
		.found(n_found),
		.src(n_src),
		.level(n_lvl)
	);
	priority_pick u_fast_pick (
		.pending(fast_pending),
		.levels(levels),
		.prio_on(fast_nest),
		.in_service(fast_isr),
		.found(f_found),
		.src(f_src),
		.level(f_lvl)
	);

	// Marks are taken only with nesting on; set_en is gated here by the path's nest bit.
	in_service_stack u_normal_isr (
		.clock(clock),
		.srst(srst),
		.set_en(rd_nvec && normal_nest && n_found),
		.set_level(n_lvl),
		.clear_en(wr_nisr),
		.state_reg(normal_isr)
	);
	in_service_stack u_fast_isr (
		.clock(clock),
		.srst(srst),
		.set_en(rd_fvec && fast_nest && f_found),
		.set_level(f_lvl),
		.clear_en(wr_fisr),
		.state_reg(fast_isr)
	);

	// A fast request that may be taken (f_found) holds the normal line off.
	assign fast_irq = f_found;
	assign normal_irq = n_found && !f_found;

	wire [DATA_W-1:0] base_field = DATA_W'(base_reg) << VEC_BASE_LSB;
	wire [DATA_W-1:0] nvec_word = base_field
		| (DATA_W'(n_src) << VEC_SRC_LSB);
	wire [DATA_W-1:0] fvec_word = base_field
		| (DATA_W'(f_src) << VEC_SRC_LSB);

	always_comb begin
		rdata_next = RESET_VALUE;
		if (rd_stb) begin
			case (addr)
				PRIORITY_LEVELS_C_ADDR: rdata_next = prio_c_reg;
				PRIORITY_LEVELS_D_ADDR: rdata_next = prio_d_reg;
				NESTING_CONTROL_ADDR: rdata_next = ctrl_reg;
				VECTOR_TABLE_BASE_ADDR: rdata_next = DATA_W'(base_reg);
				NORMAL_IN_SERVICE_ADDR: rdata_next = DATA_W'(normal_isr);
				FAST_IN_SERVICE_ADDR: rdata_next = DATA_W'(fast_isr);
				NORMAL_VECTOR_ADDR: rdata_next = nvec_word;
				FAST_VECTOR_ADDR: rdata_next = fvec_word;
				default: rdata_next = RESET_VALUE;
			endcase
		end
	end

	// Reserved bits are masked on the way in, so they always read zero.
	always_ff @(posedge clock) begin
		if (srst) begin
			prio_c_reg <= RESET_VALUE;
		end else if (wr_prio_c) begin
			prio_c_reg <= wdata & PRIO_C_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			prio_d_reg <= RESET_VALUE;
		end else if (wr_prio_d) begin
			prio_d_reg <= wdata & PRIO_D_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_reg <= RESET_VALUE;
		end else if (wr_ctrl) begin
			ctrl_reg <= wdata & CTRL_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			base_reg <= '0;
		end else if (wr_base) begin
			base_reg <= wdata[BASE_W-1:0];
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_reg <= RESET_VALUE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign rdata = rdata_reg;

	a_fast_first: assert property (@(posedge clock) disable iff (srst)
		f_found |-> !normal_irq && fast_irq)
		else $error("normal line raised over a fast request");
	a_vec_zero: assert property (@(posedge clock) disable iff (srst)
		$past(rd_fvec) |-> rdata[31:23] == 0 && rdata[1:0] == 0)
		else $error("fast vector reserved bits not zero");
	a_vec_base: assert property (@(posedge clock) disable iff (srst)
		rd_nvec |=> rdata[22:7] == $past(base_reg))
		else $error("normal vector base field wrong");
	a_no_mark: assert property (@(posedge clock) disable iff (srst)
		!fast_nest && fast_isr == 0 |=> fast_isr == 0)
		else $error("fast mark while nesting off");
	a_nmark_off: assert property (@(posedge clock) disable iff (srst)
		!normal_nest && normal_isr == 0 |=> normal_isr == 0)
		else $error("normal mark while nesting off");
	a_block_eq: assert property (@(posedge clock) disable iff (srst)
		normal_nest && n_found && normal_isr != 0 |->
		!normal_isr[n_lvl] && (normal_isr & ((8'h01 << n_lvl) - 8'h01)) == 0)
		else $error("blocked level selected");
	a_ctrl_mask: assert property (@(posedge clock) disable iff (srst)
		ctrl_reg[31:2] == 0)
		else $error("control reserved bits set");
	a_ctrl_rst: assert property (@(posedge clock)
		srst |=> ctrl_reg == 0 && prio_c_reg == 0 && normal_isr == 0)
		else $error("registers not zero after reset");

	// Register writes keep only the defined fields.
	a_prio_c_mask: assert property (@(posedge clock) disable iff (srst)
		(prio_c_reg & ~PRIO_C_MASK) == '0)
		else $error("register c reserved bits set");
	a_prio_d_mask: assert property (@(posedge clock) disable iff (srst)
		(prio_d_reg & ~PRIO_D_MASK) == '0)
		else $error("register d reserved bits set");
	a_wr_prio_c: assert property (@(posedge clock) disable iff (srst)
		wr_prio_c |=> prio_c_reg == ($past(wdata) & PRIO_C_MASK))
		else $error("register c write lost");
	a_wr_prio_d: assert property (@(posedge clock) disable iff (srst)
		wr_prio_d |=> prio_d_reg == ($past(wdata) & PRIO_D_MASK))
		else $error("register d write lost");
	a_wr_ctrl: assert property (@(posedge clock) disable iff (srst)
		wr_ctrl |=> ctrl_reg == ($past(wdata) & CTRL_MASK))
		else $error("control write lost");
	a_wr_base: assert property (@(posedge clock) disable iff (srst)
		wr_base |=> base_reg == $past(wdata[BASE_W-1:0]))
		else $error("vector base write lost");

	// Read port: data one cycle after the strobe, zero otherwise.
	a_rd_idle: assert property (@(posedge clock) disable iff (srst)
		!$past(rd_stb) |-> rdata == RESET_VALUE)
		else $error("read data outside the answer cycle");
	a_rd_ctrl: assert property (@(posedge clock) disable iff (srst)
		rd_stb && addr == NESTING_CONTROL_ADDR |=> rdata == $past(ctrl_reg))
		else $error("control read wrong");
	a_rd_prio_c: assert property (@(posedge clock) disable iff (srst)
		rd_stb && addr == PRIORITY_LEVELS_C_ADDR
		|=> rdata == $past(prio_c_reg))
		else $error("register c read wrong");
	a_rd_prio_d: assert property (@(posedge clock) disable iff (srst)
		rd_stb && addr == PRIORITY_LEVELS_D_ADDR
		|=> rdata == $past(prio_d_reg))
		else $error("register d read wrong");
	a_rd_base: assert property (@(posedge clock) disable iff (srst)
		rd_stb && addr == VECTOR_TABLE_BASE_ADDR
		|=> rdata == DATA_W'($past(base_reg)))
		else $error("vector base read wrong");
	a_rd_nisr: assert property (@(posedge clock) disable iff (srst)
		rd_stb && addr == NORMAL_IN_SERVICE_ADDR
		|=> rdata == DATA_W'($past(normal_isr)))
		else $error("normal in-service read wrong");
	a_rd_fisr: assert property (@(posedge clock) disable iff (srst)
		rd_stb && addr == FAST_IN_SERVICE_ADDR
		|=> rdata == DATA_W'($past(fast_isr)))
		else $error("fast in-service read wrong");

	// Vector words: base, source number and zero reserved bits.
	a_fvec_src: assert property (@(posedge clock) disable iff (srst)
		rd_fvec |=> rdata[VEC_SRC_LSB +: SRC_W] == $past(f_src))
		else $error("fast vector source field wrong");
	a_fvec_base: assert property (@(posedge clock) disable iff (srst)
		rd_fvec |=> rdata[VEC_BASE_LSB +: BASE_W] == $past(base_reg))
		else $error("fast vector base field wrong");
	a_nvec_src: assert property (@(posedge clock) disable iff (srst)
		rd_nvec |=> rdata[VEC_SRC_LSB +: SRC_W] == $past(n_src))
		else $error("normal vector source field wrong");
	a_nvec_zero: assert property (@(posedge clock) disable iff (srst)
		$past(rd_nvec) |-> rdata[VEC_SRC_LSB-1:0] == '0
		&& rdata[DATA_W-1:VEC_BASE_LSB+BASE_W] == '0)
		else $error("normal vector reserved bits not zero");

	// In-service marks, holds and blocking.
	a_fmark_on: assert property (@(posedge clock) disable iff (srst)
		rd_fvec && fast_nest && f_found |=> fast_isr[$past(f_lvl)])
		else $error("fast level not marked on vector read");
	a_nmark_on: assert property (@(posedge clock) disable iff (srst)
		rd_nvec && normal_nest && n_found |=> normal_isr[$past(n_lvl)])
		else $error("normal level not marked on vector read");
	a_nisr_hold: assert property (@(posedge clock) disable iff (srst)
		!wr_nisr && !(rd_nvec && normal_nest && n_found)
		|=> normal_isr == $past(normal_isr))
		else $error("normal in-service changed without cause");
	a_fisr_hold: assert property (@(posedge clock) disable iff (srst)
		!wr_fisr && !(rd_fvec && fast_nest && f_found)
		|=> fast_isr == $past(fast_isr))
		else $error("fast in-service changed without cause");
	a_fblock: assert property (@(posedge clock) disable iff (srst)
		fast_nest && f_found && fast_isr != 0 |->
		!fast_isr[f_lvl]
		&& (fast_isr & ((NUM_LVL'(1) << f_lvl) - NUM_LVL'(1))) == '0)
		else $error("blocked fast level selected");

	// Plain delivery: lowest pending number wins, fast before normal.
	a_plain_low: assert property (@(posedge clock) disable iff (srst)
		!normal_nest && normal_pending != 0 |->
		n_found && normal_pending[n_src] && (normal_pending
		& ((NUM_SRC'(1) << n_src) - NUM_SRC'(1))) == '0)
		else $error("plain normal pick not lowest source");
	a_fplain_low: assert property (@(posedge clock) disable iff (srst)
		!fast_nest && fast_pending != 0 |->
		f_found && fast_pending[f_src] && (fast_pending
		& ((NUM_SRC'(1) << f_src) - NUM_SRC'(1))) == '0)
		else $error("plain fast pick not lowest source");
	a_irq_idle: assert property (@(posedge clock) disable iff (srst)
		normal_pending == 0 && fast_pending == 0 |->
		!normal_irq && !fast_irq)
		else $error("interrupt raised with nothing pending");
	a_fast_plain: assert property (@(posedge clock) disable iff (srst)
		!fast_nest && !normal_nest && fast_pending != 0 |->
		fast_irq && !normal_irq)
		else $error("fast request not ahead of normal");
	a_normal_deliv: assert property (@(posedge clock) disable iff (srst)
		n_found && !f_found |-> normal_irq)
		else $error("normal request not delivered");
	a_nfound_pend: assert property (@(posedge clock) disable iff (srst)
		n_found |-> normal_pending != 0)
		else $error("normal pick without a pending source");
	a_ffound_pend: assert property (@(posedge clock) disable iff (srst)
		f_found |-> fast_pending != 0)
		else $error("fast pick without a pending source");
	c_nest_normal: cover property (@(posedge clock) disable iff (srst)
		rd_nvec && normal_nest && n_found);
	c_nest_fast: cover property (@(posedge clock) disable iff (srst)
		rd_fvec && fast_nest && f_found);
	c_two_deep: cover property (@(posedge clock) disable iff (srst)
		$countones(normal_isr) == 2);
	c_both: cover property (@(posedge clock) disable iff (srst)
		normal_pending != 0 && fast_pending != 0);
	c_fast_block: cover property (@(posedge clock) disable iff (srst)
		fast_nest && fast_isr != 0 && fast_pending != 0 && !f_found);
endmodule : nested_priority_interrupt_ctrl

// *** rtl/priority_pick.sv ***
// Picks the highest-priority unblocked pending source on one path.
`timescale 1ns/1ps
module priority_pick (
	input wire logic [nest_pkg::NUM_SRC-1:0] pending, // Pending sources.
	input wire logic [nest_pkg::NUM_SRC*nest_pkg::LVL_W-1:0] levels, // Levels.
	input wire logic prio_on, // Nesting and priority enabled.
	input wire logic [nest_pkg::NUM_LVL-1:0] in_service, // In-service bits.
	output logic found, // A source may be taken.
	output logic [nest_pkg::SRC_W-1:0] src, // Winning source number.
	output logic [nest_pkg::LVL_W-1:0] level // Winning source level.
);
	import nest_pkg::*;
	// Levels at or above the lowest in-service index are blocked.
	logic [NUM_LVL-1:0] allowed;
	always_comb begin
		allowed = '1;
		for (int i = NUM_LVL - 1; i >= 0; i--) begin
			if (in_service[i]) begin
				allowed = (NUM_LVL'(1) << i) - NUM_LVL'(1);
			end
		end
	end
	always_comb begin
		found = 1'b0;
		src = '0;
		level = '0;
		for (int s = NUM_SRC - 1; s >= 0; s--) begin
			if (!prio_on) begin
				if (pending[s]) begin
					found = 1'b1;
					src = SRC_W'(s);
					level = '0;
				end
			end else if (pending[s] && allowed[levels[s*LVL_W +: LVL_W]]
				&& (!found || levels[s*LVL_W +: LVL_W] <= level)) begin
				found = 1'b1;
				src = SRC_W'(s);
				level = levels[s*LVL_W +: LVL_W];
			end
		end
	end
endmodule : priority_pick

// *** testbench/irq_source_model.sv ***
// Behavioural model of the peripheral sources that drive the pending lines.
`timescale 1ns/1ps
module irq_source_model (
	input wire logic clock, // System clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [nest_pkg::NUM_SRC-1:0] normal_req, // Normal causes.
	input wire logic [nest_pkg::NUM_SRC-1:0] fast_req, // Fast causes.
	output logic [nest_pkg::NUM_SRC-1:0] normal_pending, // Normal lines.
	output logic [nest_pkg::NUM_SRC-1:0] fast_pending // Fast lines.
);
	import nest_pkg::*;
	// A source holds its line as a level until its cause is withdrawn.
	always_ff @(posedge clock) begin
		if (srst) begin
			normal_pending <= '0;
			fast_pending <= '0;
		end else begin
			normal_pending <= normal_req;
			fast_pending <= fast_req;
		end
	end
endmodule : irq_source_model

// *** testbench/nested_priority_interrupt_ctrl_bench.sv ***
// Self-checking bench for the nesting and priority block.
`timescale 1ns/1ps
module nested_priority_interrupt_ctrl_bench;
	import nest_pkg::*;
	localparam logic [BASE_W-1:0] TB_BASE = 16'hABCD;
	logic clock;
	logic srst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic wr_stb;
	logic rd_stb;
	logic [DATA_W-1:0] rdata;
	logic [NUM_SRC-1:0] normal_req;
	logic [NUM_SRC-1:0] fast_req;
	logic [NUM_SRC-1:0] normal_pending;
	logic [NUM_SRC-1:0] fast_pending;
	logic [NUM_SRC*LVL_W-1:0] low_levels;
	logic normal_irq;
	logic fast_irq;
	logic [DATA_W-1:0] seen;
	int err_total;
	int check_count;

	nested_priority_interrupt_ctrl u_nested_priority_interrupt_ctrl (
		.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.normal_pending(normal_pending), .fast_pending(fast_pending),
		.low_levels(low_levels), .normal_irq(normal_irq),
		.fast_irq(fast_irq));
	irq_source_model u_irq_source_model (
		.clock(clock), .srst(srst), .normal_req(normal_req),
		.fast_req(fast_req), .normal_pending(normal_pending),
		.fast_pending(fast_pending));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(input logic [DATA_W-1:0] s,
		input logic [DATA_W-1:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clock);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		seen = rdata;
	endtask : rd

	task automatic req(input logic fast, input logic [NUM_SRC-1:0] v);
		@(posedge clock);
		if (fast) fast_req <= v;
		else normal_req <= v;
		repeat (2) @(posedge clock);
		#1;
	endtask : req

	task automatic chk_irq(input logic fast, input logic e);
		check(32'(fast ? fast_irq : normal_irq), 32'(e));
	endtask : chk_irq

	function automatic logic [DATA_W-1:0] vec(input logic [SRC_W-1:0] s);
		return {9'h000, TB_BASE, s, 2'b00};
	endfunction : vec

	task automatic test_reset();
		logic [ADDR_W-1:0] map [8];
		map = '{VECTOR_TABLE_BASE_ADDR, NORMAL_VECTOR_ADDR,
			PRIORITY_LEVELS_C_ADDR, PRIORITY_LEVELS_D_ADDR,
			NESTING_CONTROL_ADDR, NORMAL_IN_SERVICE_ADDR,
			FAST_VECTOR_ADDR, FAST_IN_SERVICE_ADDR};
		foreach (map[i]) begin
			rd(map[i]);
			check(seen, RESET_VALUE);
		end
		$display("test_reset done");
	endtask : test_reset

	task automatic test_masks();
		wr(PRIORITY_LEVELS_C_ADDR, 32'hFFFFFFFF);
		rd(PRIORITY_LEVELS_C_ADDR);
		check(seen, 32'h77777777);
		wr(PRIORITY_LEVELS_D_ADDR, 32'hFFFFFFFF);
		rd(PRIORITY_LEVELS_D_ADDR);
		check(seen, 32'h00007777);
		wr(NESTING_CONTROL_ADDR, 32'hFFFFFFFF);
		rd(NESTING_CONTROL_ADDR);
		check(seen, 32'h00000003);
		wr(VECTOR_TABLE_BASE_ADDR, 32'hFFFFFFFF);
		rd(VECTOR_TABLE_BASE_ADDR);
		check(seen, 32'h0000FFFF);
		wr(32'hFFFF0040, 32'hFFFFFFFF);
		rd(32'hFFFF0040);
		check(seen, 32'h00000000);
		$display("test_masks done");
	endtask : test_masks

	// Without nesting the lowest source number wins and nothing is marked.
	task automatic test_plain();
		wr(NESTING_CONTROL_ADDR, 32'h00000000);
		wr(VECTOR_TABLE_BASE_ADDR, {16'h0000, TB_BASE});
		wr(PRIORITY_LEVELS_C_ADDR, 32'h00007000);
		normal_req <= 28'h0800000;
		req(1'b1, 28'h0880000);
		chk_irq(1'b1, 1'b1);
		chk_irq(1'b0, 1'b0);
		rd(FAST_VECTOR_ADDR);
		check(seen, vec(5'(SRC_EXT0)));
		rd(FAST_IN_SERVICE_ADDR);
		check(seen, 32'h00000000);
		req(1'b1, '0);
		chk_irq(1'b0, 1'b1);
		normal_req <= '0;
		req(1'b0, '0);
		$display("test_plain done");
	endtask : test_plain

	// Vectors are read only after the path has raised its interrupt.
	task automatic nest_path(input logic [DATA_W-1:0] ctl,
		input logic [ADDR_W-1:0] va, input logic [ADDR_W-1:0] ia,
		input logic fast);
		wr(NESTING_CONTROL_ADDR, ctl);
		wr(PRIORITY_LEVELS_C_ADDR, 32'h20005000);
		wr(PRIORITY_LEVELS_D_ADDR, 32'h00000001);
		req(fast, 28'h0880000);
		chk_irq(fast, 1'b1);
		rd(va);
		check(seen, vec(5'(SRC_PWM)));
		rd(ia);
		check(seen, 32'h00000004);
		chk_irq(fast, 1'b0);
		req(fast, 28'h1880000);
		chk_irq(fast, 1'b1);
		rd(va);
		check(seen, vec(5'(SRC_EXT4)));
		rd(ia);
		check(seen, 32'h00000006);
		wr(ia, 32'hFFFFFFFF);
		rd(ia);
		check(seen, 32'h00000004);
		wr(ia, 32'hFFFFFFFF);
		rd(ia);
		check(seen, 32'h00000000);
		req(fast, '0);
		$display("nest_path done fast=%0b", fast);
	endtask : nest_path

	task automatic summarize();
		$display("Checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize

	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		summarize();
	end

	initial begin
		srst = 1'b1;
		addr = '0;
		wdata = '0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		normal_req = '0;
		fast_req = '0;
		low_levels = '0;
		err_total = 0;
		check_count = 0;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		test_reset();
		test_masks();
		test_plain();
		nest_path(32'h00000002, FAST_VECTOR_ADDR, FAST_IN_SERVICE_ADDR, 1'b1);
		nest_path(32'h00000001, NORMAL_VECTOR_ADDR, NORMAL_IN_SERVICE_ADDR,
			1'b0);
		summarize();
	end
endmodule : nested_priority_interrupt_ctrl_bench
